// ---- hdl/dma_steer_pkg.sv ----
// Constants for the motherboard DMA steering block.
// Assumes an 8-bit register port with byte offsets.
package dma_steer_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] STEER_0_OFFSET = 8'h76;
   localparam logic [7:0] STEER_1_OFFSET = 8'h77;
   localparam logic [7:0] STEER_RESET    = 8'h0c;

   // ---------------------------------------------------------------
   // Field layout
   // ---------------------------------------------------------------
   localparam int         FAST_BIT       = 7;
   localparam int         DISABLE_BIT    = 3;
   localparam int         CHAN_LSB       = 0;
   localparam int         CHAN_W         = 3;
   localparam logic [7:0] WRITE_MASK     = 8'h8f;
   localparam logic [2:0] CHAN_NONE      = 3'h4;

   // ---------------------------------------------------------------
   // Timing and counts
   // ---------------------------------------------------------------
   localparam int         FAST_SYSCLKS   = 3;
   localparam int         NUM_CHAN       = 8;
   localparam int         NUM_PAIRS      = 2;

endpackage

// ---- hdl/steer_decode.sv ----
// One steering register's channel decode.
// Assumes a registered field value from the same clock domain.
`timescale 1ns/1ns
module steer_decode
   import dma_steer_pkg::*;
(
   // Register field
   input  wire logic [7:0] reg_value,
   input  wire logic       full_variant,
   // Decoded one-hot selections
   output logic [7:0]      route_sel,
   output logic [7:0]      fast_sel
);

   logic [2:0] chan;
   logic [7:0] chan_hot;
   logic       fast_on;
   logic       routed;

   assign chan     = reg_value[CHAN_LSB +: CHAN_W];
   assign fast_on  = reg_value[FAST_BIT];
   // Code 100 selects no channel; others are one-hot
   assign chan_hot = (chan == CHAN_NONE) ? 8'h00 : (8'h01 << chan);
   assign routed   = full_variant & ~reg_value[DISABLE_BIT];
   assign route_sel = routed ? chan_hot : 8'h00;
   assign fast_sel  = fast_on ? chan_hot : 8'h00;

endmodule

// ---- hdl/board_dma_steering.sv ----
// Motherboard DMA steering registers and request/acknowledge routing.
// Assumes board and ISA request pins are asynchronous, controller on clk.
// Behaviour
// - Each register can enable three-clock fast transfers on its channel.
// - Bit 7 enables fast timing and buffer for the low-three-bit channel.
// - Disable bit zero routes board pair onto the selected channel.
// - Disable bit one serves the channel from its ISA pair.
// - Steered channel masks its ISA request and acknowledge pins.
// - Disable bit one masks board request and idles board acknowledge.
// - Routed with fast set: fast timing and buffer for board peripheral.
// - Not routed with fast set: fast timing and buffer for ISA peripheral.
// - Codes 0-3 pick channels 0-3, code 4 none, 5-7 channels 5-7.
// - Reduced variant: no steering, bit 3 reserved, only fast selection.
// - Registers reset to 0x0c and are readable and writable.
// - Register for pair 0 at 0x76, pair 1 at 0x77.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
module board_dma_steering
   import dma_steer_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Variant select, high for the full steering variant
   input  wire logic       full_variant,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic [7:0]      reg_rdata,
   // Board peripheral pins
   input  wire logic [1:0] board_dma_request,
   output logic [1:0]      board_dma_acknowledge_n,
   // ISA peripheral pins
   input  wire logic [7:0] isa_dma_request,
   output logic [7:0]      isa_dma_acknowledge_n,
   // Internal controller side
   output logic [7:0]      ctrl_dma_request,
   input  wire logic [7:0] ctrl_dma_acknowledge_n,
   output logic [7:0]      fast_enable,
   output logic [7:0]      fast_board
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] steer_q [NUM_PAIRS];
   logic [7:0] steer_d [NUM_PAIRS];
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic       hit0;
   logic       hit1;

   assign hit0 = (reg_addr == STEER_0_OFFSET);
   assign hit1 = (reg_addr == STEER_1_OFFSET);

   assign steer_d[0] = (reg_write && hit0) ? (reg_wdata & WRITE_MASK)
                                           : steer_q[0];
   assign steer_d[1] = (reg_write && hit1) ? (reg_wdata & WRITE_MASK)
                                           : steer_q[1];

   assign rdata_d = !reg_read ? 8'h00 :
                    hit0      ? steer_q[0] :
                    hit1      ? steer_q[1] :
                                8'h00;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         steer_q[0] <= STEER_RESET;
         steer_q[1] <= STEER_RESET;
         rdata_q    <= 8'h00;
      end else begin
         steer_q[0] <= steer_d[0];
         steer_q[1] <= steer_d[1];
         rdata_q    <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] board_req_m;
   logic [1:0] board_req_s;
   logic [7:0] isa_req_m;
   logic [7:0] isa_req_s;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         board_req_m <= 2'h0;
         board_req_s <= 2'h0;
         isa_req_m   <= 8'h00;
         isa_req_s   <= 8'h00;
      end else begin
         board_req_m <= board_dma_request;
         board_req_s <= board_req_m;
         isa_req_m   <= isa_dma_request;
         isa_req_s   <= isa_req_m;
      end
   end

   // ---------------------------------------------------------------
   // Channel decode
   // ---------------------------------------------------------------
   logic [7:0] route_sel [NUM_PAIRS];
   logic [7:0] fast_sel  [NUM_PAIRS];

   steer_decode u_dec0 (
      .reg_value    (steer_q[0]),
      .full_variant (full_variant),
      .route_sel    (route_sel[0]),
      .fast_sel     (fast_sel[0])
   );

   steer_decode u_dec1 (
      .reg_value    (steer_q[1]),
      .full_variant (full_variant),
      .route_sel    (route_sel[1]),
      .fast_sel     (fast_sel[1])
   );

   // ---------------------------------------------------------------
   // Routing
   // ---------------------------------------------------------------
   logic [7:0] board_owned;
   logic [7:0] board_req_ch;
   logic [7:0] req_d;
   logic [7:0] isa_ack_d;
   logic [1:0] board_ack_d;
   logic [7:0] fast_d;
   logic [7:0] fast_board_d;

   // Overlapping steering is a software error; OR keeps it bounded
   assign board_owned  = route_sel[0] | route_sel[1];
   assign board_req_ch = (route_sel[0] & {8{board_req_s[0]}})
                       | (route_sel[1] & {8{board_req_s[1]}});
   // Owned channels drop ISA request; others keep it
   assign req_d = (isa_req_s & ~board_owned) | board_req_ch;
   assign isa_ack_d = ctrl_dma_acknowledge_n | board_owned;
   assign board_ack_d[0] = ~|(route_sel[0] & ~ctrl_dma_acknowledge_n);
   assign board_ack_d[1] = ~|(route_sel[1] & ~ctrl_dma_acknowledge_n);
   // Fast timing, three bus clocks per transfer in the controller
   assign fast_d       = fast_sel[0] | fast_sel[1];
   assign fast_board_d = (fast_sel[0] & route_sel[0])
                       | (fast_sel[1] & route_sel[1]);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_dma_request        <= 8'h00;
         isa_dma_acknowledge_n   <= 8'hff;
         board_dma_acknowledge_n <= 2'h3;
         fast_enable             <= 8'h00;
         fast_board              <= 8'h00;
      end else begin
         ctrl_dma_request        <= req_d;
         isa_dma_acknowledge_n   <= isa_ack_d;
         board_dma_acknowledge_n <= board_ack_d;
         fast_enable             <= fast_d;
         fast_board              <= fast_board_d;
      end
   end

endmodule

// ---- testbench/dma_ctrl_model.sv ----
// Controller model: acks each request it sees, at once or after a stall.
// Assumes one clock shared with the steering block.
`timescale 1ns/1ns
module dma_ctrl_model (
   // Clock, reset, pace
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       slow,
   // Requests in, acks out
   input wire logic [7:0] ctrl_dma_request,
   output logic [7:0]     ctrl_dma_acknowledge_n
);
   logic [7:0] req_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         req_q <= 8'h00;
         ctrl_dma_acknowledge_n <= 8'hff;
      end else begin
         req_q <= ctrl_dma_request;
         ctrl_dma_acknowledge_n <= ~(ctrl_dma_request & (slow ? req_q : 8'hff));
      end
   end
endmodule

// ---- testbench/board_dma_steering_monitor.sv ----
// Port checks for the steering block.
// Assumes binding to board_dma_steering.
`timescale 1ns/1ns
module steer_monitor (
   // Clock, reset, variant
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       full_variant,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   // Acks and fast selection
   input wire logic [1:0] board_dma_acknowledge_n,
   input wire logic [7:0] isa_dma_acknowledge_n,
   input wire logic [7:0] ctrl_dma_acknowledge_n,
   input wire logic [7:0] fast_enable,
   input wire logic [7:0] fast_board
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_idle; !reg_read || reg_addr[7:1] != 7'h3b; endsequence
   a_rdata_idle: assert property (s_idle |=> reg_rdata == 8'h00)
      else $error("rdata not zero");
   a_reserved_zero: assert property (reg_read |=> reg_rdata[6:4] == 3'h0)
      else $error("reserved bits set");
   a_no_code4: assert property (fast_enable[4] == 1'b0)
      else $error("fast on channel 4");
   a_fast_pair: assert property ($countones(fast_enable) <= 2)
      else $error("too many fast channels");
   a_board_fast: assert property ((fast_board & ~fast_enable) == 8'h00)
      else $error("board fast alone");
   a_isa_ack: assert property (&(isa_dma_acknowledge_n | ~$past(ctrl_dma_acknowledge_n)))
      else $error("isa ack without cause");
   a_board_ack: assert property (board_dma_acknowledge_n != 2'b11 |->
      $past(ctrl_dma_acknowledge_n) != 8'hff) else $error("board ack without cause");
   a_reduced_quiet: assert property (!full_variant [*2] |-> fast_board == 8'h00
      && board_dma_acknowledge_n == 2'b11) else $error("reduced variant steers");
endmodule
bind board_dma_steering steer_monitor mon (.*);

// ---- testbench/board_dma_steering_tb.sv ----
// Self-checking bench for the steering block.
// Assumes the controller model and the bound checker.
`timescale 1ns/1ns
module board_dma_steering_tb;
   import dma_steer_pkg::*;
   logic        clk = 0, rst_b = 0, full_variant = 0, slow = 0, snap = 0, rd_q = 0, p;
   logic        reg_write = 0, reg_read = 0;
   logic [1:0]  board_dma_request = 0, board_dma_acknowledge_n;
   logic [7:0]  reg_addr = 0, reg_wdata = 0, isa_dma_request = 0, reg_rdata, v, own, fe, rq;
   logic [7:0]  isa_dma_acknowledge_n, ctrl_dma_request, ctrl_dma_acknowledge_n;
   logic [7:0]  fast_enable, fast_board, rd_exp[$];
   logic [31:0] seed = 32'he265;
   logic [33:0] route_q[$];
   int          errors = 0, total_checks = 0;
   always #50 clk = ~clk;
   board_dma_steering dut (.*);
   dma_ctrl_model ctrl (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [33:0] e, g);
      total_checks++;
      if (e !== g) begin
         errors++;
         $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic cyc(input logic w, r, input logic [7:0] a, d, e);
      if (r) rd_exp.push_back(e);
      reg_write <= w;
      reg_read <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) rd_q <= reg_read;
   always @(negedge clk) if (rd_q) chk({26'h0, rd_exp.pop_front()}, {26'h0, reg_rdata});
   always @(negedge clk) if (snap) chk(route_q.pop_front(), {ctrl_dma_request,
      isa_dma_acknowledge_n, board_dma_acknowledge_n, fast_enable, fast_board});
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      cyc(0, 1, STEER_0_OFFSET, 0, STEER_RESET);
      cyc(0, 1, STEER_1_OFFSET, 0, STEER_RESET);
      cyc(1, 0, 8'h78, 8'hff, 0);
      cyc(0, 1, 8'h78, 0, 8'h00);
      $display("register map test done");
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         v = {seed[7:3], i[2:0]};
         p = seed[8];
         full_variant <= seed[9];
         slow <= seed[10];
         isa_dma_request <= seed[23:16];
         board_dma_request <= {2{seed[11]}};
         own = (seed[9] && !v[3] && v[2:0] != 3'h4) ? 8'h01 << v[2:0] : 8'h00;
         fe = (v[7] && v[2:0] != 3'h4) ? 8'h01 << v[2:0] : 8'h00;
         rq = (seed[23:16] & ~own) | (seed[11] ? own : 8'h00);
         cyc(1, 0, 8'h76 + {7'h00, p}, v, 0);
         cyc(1, 0, 8'h77 - {7'h00, p}, STEER_RESET, 0);
         cyc(0, 1, 8'h76 + {7'h00, p}, 0, v & WRITE_MASK);
         cyc(0, 0, 0, 0, 0);
         repeat (12) @(posedge clk);
         route_q.push_back({rq, ~(rq & ~own), (own != 0 && seed[11]) ? ~{p, !p} : 2'b11,
                            fe, fe & own});
         snap <= 1;
         @(posedge clk);
         snap <= 0;
      end
      $display("routing test done");
      wrap_up;
   end
   initial begin
      #1000000;
      errors++;
      wrap_up;
   end
endmodule
